// >>> rtl/mgw_buf.sv
`timescale 1ns/1ps
module mgw_buf #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);

  logic [W-1:0] d0_r;
  logic [W-1:0] d0_nxt;
  logic [W-1:0] d1_r;
  logic [W-1:0] d1_nxt;
  logic [1:0]   cnt_r;
  logic [1:0]   cnt_nxt;
  logic         push;
  logic         pop;

  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = d0_r;

  always_comb
  begin
    d0_nxt  = d0_r;
    d1_nxt  = d1_r;
    cnt_nxt = cnt_r;
    if (pop)
    begin
      d0_nxt = d1_r;
    end
    if (push)
    begin
      if (cnt_r == 2'h0 || (cnt_r == 2'h1 && pop))
      begin
        d0_nxt = in_data;
      end
      else
      begin
        d1_nxt = in_data;
      end
    end
    cnt_nxt = 2'(cnt_r + {1'b0, push} - {1'b0, pop});
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      d0_r      <= '0;
      d1_r      <= '0;
      cnt_r     <= 2'h0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      d0_r      <= d0_nxt;
      d1_r      <= d1_nxt;
      cnt_r     <= cnt_nxt;
      in_ready  <= (cnt_nxt != 2'h2);
      out_valid <= (cnt_nxt != 2'h0);
    end
  end

endmodule

// >>> rtl/mgw_gateway.sv
// Functional notes
// RL1 - Requests on TCP port 502 are taken and forwarded as RTU frames
// RL2 - Unit ID 255 or own serial unit ID is handled locally
// RL3 - Any other unit ID is forwarded onto the serial network
// RL4 - Broadcast unit ID 0 is always handled locally
// RL5 - A setting decides whether broadcasts are also forwarded serially
// RL6 - Open TCP connections are limited to the configured maximum
// RL7 - Gateway works only with protocol RTU or Jbus
// RL8 - Mode gateway enables forwarding, slave mode disables it
// RL9 - Reply timeout 0.1 to 10 s; on expiry an exception goes back
// RL10 - New serial request waits a 0 to 100 ms gap after a response
// RL11 - Silent interval is 3.5 characters plus 0 to 15 extension
// RL12 - After the silent interval the next character starts a new message
// RL13 - Slaves use the same baud rate and parity as the gateway
// RL14 - Every device on the serial network has a unique unit ID
// RL15 - Timeout, gap and extension apply only in gateway mode
// RL16 - One forwarded request outstanding at a time; others queue
`timescale 1ns/1ps
module mgw_gateway
  import mgw_pkg::*;
#(
  parameter int TICK_CYC = TICK_NS / CLK_PERIOD_NS
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              req_valid,
  input  wire mgw_req_s          req_data,
  output logic                   req_ready,
  output logic                   req_drop,
  input  wire logic              conn_open,
  input  wire logic              conn_close,
  output logic                   conn_accept,
  output logic                   conn_reject,
  output logic [CONN_W-1:0]      conn_count,
  input  wire logic              cfg_mode_gw,
  input  wire mgw_proto_e        cfg_proto,
  input  wire logic              cfg_bcast_fwd,
  input  wire logic [7:0]        cfg_own_unit,
  input  wire logic [CONN_W-1:0] cfg_max_conn,
  input  wire logic [3:0]        cfg_tmo_sel,
  input  wire logic [3:0]        cfg_gap_sel,
  input  wire logic [3:0]        cfg_sil_ext,
  input  wire logic [15:0]       cfg_char_cyc,
  output logic                   gw_active,
  output logic                   loc_valid,
  output mgw_req_s               loc_data,
  input  wire logic              loc_ready,
  output logic                   ser_tx_valid,
  output mgw_req_s               ser_tx_data,
  input  wire logic              ser_tx_ready,
  input  wire logic              ser_rx_char,
  output logic                   frame_start,
  output logic                   resp_done,
  output logic                   exc_valid,
  output mgw_req_s               exc_data
);

  localparam int TICK_W = $clog2(TICK_CYC + 1);

  // Gateway enable and effective settings
  logic             gw_on;
  logic [3:0]       ext_eff;
  logic [3:0]       gap_eff;
  logic [TMO_W-1:0] tmo_lim;
  logic [GAP_W-1:0] gap_lim;
  logic [SIL_W-1:0] sil_lim;

  assign gw_on   = cfg_mode_gw & (cfg_proto == MGW_PROTO_RTU || cfg_proto == MGW_PROTO_JBUS); // RL7 RL8
  assign ext_eff = gw_on ? cfg_sil_ext : 4'h0; // RL15
  assign gap_eff = !gw_on ? 4'h0 : (cfg_gap_sel > GAP_MAX_SEL) ? GAP_MAX_SEL : cfg_gap_sel; // RL15
  assign gap_lim = GAP_W'(gap_eff * GAP_STEP_MS * TICKS_PER_MS); // RL10
  // Widen before the product so long characters do not wrap
  assign sil_lim = SIL_W'(({6'h00, cfg_char_cyc} * (SIL_BASE_HALF + {1'b0, ext_eff, 1'b0})) >> 1); // RL11

  always_comb
  begin
    tmo_lim = TMO_W'(TMO_MS[TMO_N-1] * TICKS_PER_MS);
    if (int'(cfg_tmo_sel) < TMO_N)
    begin
      tmo_lim = TMO_W'(TMO_MS[cfg_tmo_sel] * TICKS_PER_MS); // RL9
    end
  end

  // Timebase tick
  logic [TICK_W-1:0] tick_cnt_r;
  logic [TICK_W-1:0] tick_cnt_nxt;
  logic              tick;
  logic              tick_rst;

  assign tick = (tick_cnt_r == TICK_W'(TICK_CYC - 1));

  always_comb
  begin
    tick_cnt_nxt = (tick || tick_rst) ? '0 : TICK_W'(tick_cnt_r + 1'b1);
  end

  // Connection limit
  logic [CONN_W-1:0] conn_cnt_nxt;
  logic              acc_nxt;

  always_comb
  begin
    acc_nxt      = conn_open & (conn_count < cfg_max_conn); // RL6
    conn_cnt_nxt = conn_count;
    if (acc_nxt && !(conn_close && conn_count != '0))
    begin
      conn_cnt_nxt = CONN_W'(conn_count + 1'b1);
    end
    else if (!acc_nxt && conn_close && conn_count != '0)
    begin
      conn_cnt_nxt = CONN_W'(conn_count - 1'b1);
    end
  end

  // Request routing through a one-entry hold stage
  mgw_req_s hold_r;
  mgw_req_s hold_nxt;
  logic     hold_v_r;
  logic     hold_v_nxt;
  logic     port_ok;
  logic     is_self;
  logic     is_bcast;
  logic     to_loc;
  logic     to_fwd;
  logic     loc_free;
  logic     buf_in_ready;
  logic     dispatch;
  logic     drop_nxt;
  logic     loc_v_nxt;
  mgw_req_s loc_d_nxt;

  assign port_ok  = (hold_r.port == MB_TCP_PORT); // RL1
  assign is_self  = (hold_r.unit == UNIT_SELF) || (hold_r.unit == cfg_own_unit); // RL2
  assign is_bcast = (hold_r.unit == UNIT_BCAST);
  assign to_loc   = port_ok & (is_self | is_bcast | !gw_on); // RL4
  assign to_fwd   = port_ok & gw_on & (is_bcast ? cfg_bcast_fwd : !is_self); // RL3 RL5
  assign loc_free = !loc_valid | loc_ready;
  assign dispatch = hold_v_r & (!to_loc | loc_free) & (!to_fwd | buf_in_ready);

  always_comb
  begin
    hold_nxt   = hold_r;
    hold_v_nxt = hold_v_r & !dispatch;
    if (req_valid && req_ready)
    begin
      hold_nxt   = req_data;
      hold_v_nxt = 1'b1;
    end
    drop_nxt  = dispatch & !port_ok;
    loc_v_nxt = loc_valid & !loc_ready;
    loc_d_nxt = loc_data;
    if (dispatch && to_loc)
    begin
      loc_v_nxt = 1'b1;
      loc_d_nxt = hold_r;
    end
  end

  // Queue of forwarded requests
  logic     buf_out_valid;
  mgw_req_s buf_out_data;
  logic     buf_pop;

  mgw_buf #(
    .W (REQ_W)
  ) u_buf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (dispatch & to_fwd),
    .in_data   (hold_r),
    .in_ready  (buf_in_ready),
    .out_valid (buf_out_valid),
    .out_data  (buf_out_data),
    .out_ready (buf_pop)
  );

  // Serial silence tracking
  logic [SIL_W-1:0] sil_cnt_r;
  logic [SIL_W-1:0] sil_cnt_nxt;
  logic             sil_idle;

  assign sil_idle = (sil_cnt_r >= sil_lim);

  always_comb
  begin
    sil_cnt_nxt = sil_cnt_r;
    if (ser_rx_char)
    begin
      sil_cnt_nxt = '0;
    end
    else if (!sil_idle)
    begin
      sil_cnt_nxt = SIL_W'(sil_cnt_r + 1'b1);
    end
  end

  // Serial transaction engine
  mgw_state_e       st_r;
  mgw_state_e       st_nxt;
  logic [TMO_W-1:0] tmo_cnt_r;
  logic [TMO_W-1:0] tmo_cnt_nxt;
  logic [GAP_W-1:0] gap_cnt_r;
  logic [GAP_W-1:0] gap_cnt_nxt;
  logic             tx_v_nxt;
  mgw_req_s         tx_d_nxt;
  logic             exc_nxt;
  logic             done_nxt;

  assign buf_pop = (st_r == MGW_ST_IDLE) & buf_out_valid; // RL16

  // Restart the tick at each timed wait so no wait ends a tick short
  assign tick_rst = (st_nxt != st_r) && (st_nxt == MGW_ST_WAIT || st_nxt == MGW_ST_GAP); // RL9 RL10

  always_comb
  begin
    st_nxt      = st_r;
    tmo_cnt_nxt = tmo_cnt_r;
    gap_cnt_nxt = gap_cnt_r;
    tx_v_nxt    = ser_tx_valid;
    tx_d_nxt    = ser_tx_data;
    exc_nxt     = 1'b0;
    done_nxt    = 1'b0;
    case (st_r)
      MGW_ST_IDLE:
      begin
        if (buf_out_valid)
        begin
          tx_v_nxt = 1'b1;
          tx_d_nxt = buf_out_data;
          st_nxt   = MGW_ST_SEND;
        end
      end
      MGW_ST_SEND:
      begin
        if (ser_tx_ready)
        begin
          tx_v_nxt    = 1'b0;
          tmo_cnt_nxt = '0;
          gap_cnt_nxt = '0;
          st_nxt      = (ser_tx_data.unit == UNIT_BCAST) ? MGW_ST_GAP : MGW_ST_WAIT;
        end
      end
      MGW_ST_WAIT:
      begin
        if (ser_rx_char)
        begin
          st_nxt = MGW_ST_RECV;
        end
        else if (tmo_cnt_r >= tmo_lim)
        begin
          exc_nxt = 1'b1; // RL9
          st_nxt  = MGW_ST_IDLE;
        end
        else if (tick)
        begin
          tmo_cnt_nxt = TMO_W'(tmo_cnt_r + 1'b1);
        end
      end
      MGW_ST_RECV:
      begin
        if (sil_idle && !ser_rx_char)
        begin
          done_nxt    = 1'b1;
          gap_cnt_nxt = '0;
          st_nxt      = MGW_ST_GAP;
        end
      end
      MGW_ST_GAP:
      begin
        if (gap_cnt_r >= gap_lim)
        begin
          st_nxt = MGW_ST_IDLE; // RL10
        end
        else if (tick)
        begin
          gap_cnt_nxt = GAP_W'(gap_cnt_r + 1'b1);
        end
      end
      default:
      begin
        st_nxt   = MGW_ST_IDLE;
        tx_v_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tick_cnt_r   <= '0;
      conn_count   <= '0;
      conn_accept  <= 1'b0;
      conn_reject  <= 1'b0;
      hold_r       <= '0;
      hold_v_r     <= 1'b0;
      req_ready    <= 1'b0;
      req_drop     <= 1'b0;
      loc_valid    <= 1'b0;
      loc_data     <= '0;
      sil_cnt_r    <= '0;
      frame_start  <= 1'b0;
      st_r         <= MGW_ST_IDLE;
      tmo_cnt_r    <= '0;
      gap_cnt_r    <= '0;
      ser_tx_valid <= 1'b0;
      ser_tx_data  <= '0;
      exc_valid    <= 1'b0;
      exc_data     <= '0;
      resp_done    <= 1'b0;
      gw_active    <= 1'b0;
    end
    else
    begin
      tick_cnt_r   <= tick_cnt_nxt;
      conn_count   <= conn_cnt_nxt;
      conn_accept  <= acc_nxt;
      conn_reject  <= conn_open & !acc_nxt; // RL6
      hold_r       <= hold_nxt;
      hold_v_r     <= hold_v_nxt;
      req_ready    <= !hold_v_nxt;
      req_drop     <= drop_nxt;
      loc_valid    <= loc_v_nxt;
      loc_data     <= loc_d_nxt;
      sil_cnt_r    <= sil_cnt_nxt;
      frame_start  <= ser_rx_char & sil_idle; // RL12
      st_r         <= st_nxt;
      tmo_cnt_r    <= tmo_cnt_nxt;
      gap_cnt_r    <= gap_cnt_nxt;
      ser_tx_valid <= tx_v_nxt;
      ser_tx_data  <= tx_d_nxt;
      exc_valid    <= exc_nxt;
      exc_data     <= exc_nxt ? ser_tx_data : exc_data;
      resp_done    <= done_nxt;
      gw_active    <= gw_on;
    end
  end

endmodule

// >>> rtl/mgw_pkg.sv
package mgw_pkg;

  // Clock and timebase
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 100000;
  localparam int TICKS_PER_MS  = 1000000 / TICK_NS;

  // Addressing
  localparam logic [15:0] MB_TCP_PORT = 16'h01F6;
  localparam logic [7:0]  UNIT_SELF   = 8'hFF;
  localparam logic [7:0]  UNIT_BCAST  = 8'h00;

  // Response timeout choices in ms
  localparam int TMO_N = 15;
  localparam int TMO_MS [TMO_N] = '{100, 200, 300, 400, 500, 1000, 2000, 3000,
                                    4000, 5000, 6000, 7000, 8000, 9000, 10000};
  localparam int TMO_W = 17;

  // Inter-frame gap: selector times step, capped
  localparam int          GAP_STEP_MS = 10;
  localparam logic [3:0]  GAP_MAX_SEL = 4'hA;
  localparam int          GAP_W       = 10;

  // Silent interval in half characters: 3.5 chars plus extension
  localparam logic [5:0]  SIL_BASE_HALF = 6'h07;
  localparam int          SIL_W         = 22;

  localparam int CONN_W = 4;

  typedef enum logic [1:0] {
    MGW_PROTO_RTU   = 2'h0,
    MGW_PROTO_JBUS  = 2'h1,
    MGW_PROTO_OTHER = 2'h2
  } mgw_proto_e;

  typedef enum logic [2:0] {
    MGW_ST_IDLE = 3'h0,
    MGW_ST_SEND = 3'h1,
    MGW_ST_WAIT = 3'h2,
    MGW_ST_RECV = 3'h3,
    MGW_ST_GAP  = 3'h4
  } mgw_state_e;

  typedef struct packed {
    logic [15:0]       port;
    logic [CONN_W-1:0] conn;
    logic [7:0]        unit;
    logic [7:0]        func;
  } mgw_req_s;

  localparam int REQ_W = $bits(mgw_req_s);

endpackage

// >>> sim/mgw_checker.sv
`timescale 1ns/1ps
module mgw_checker
  import mgw_pkg::*;
(
  input logic              clk,
  input logic              rst,
  input logic              req_valid,
  input mgw_req_s          req_data,
  input logic              req_ready,
  input logic              req_drop,
  input logic              conn_open,
  input logic              conn_accept,
  input logic              conn_reject,
  input logic [CONN_W-1:0] conn_count,
  input logic [CONN_W-1:0] cfg_max_conn,
  input logic              cfg_mode_gw,
  input mgw_proto_e        cfg_proto,
  input logic              gw_active,
  input logic              loc_valid,
  input mgw_req_s          loc_data,
  input logic              loc_ready,
  input logic              ser_tx_valid,
  input mgw_req_s          ser_tx_data,
  input logic              ser_tx_ready,
  input logic              ser_rx_char,
  input logic              frame_start,
  input logic              exc_valid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence bad_port_s;
    req_valid && req_ready && req_data.port != MB_TCP_PORT;
  endsequence
  sequence tx_done_s;
    ser_tx_valid && ser_tx_ready;
  endsequence

  port_drop_a: assert property (bad_port_s |-> ##2 req_drop) else $error("drop pulse missing");
  conn_acc_a: assert property (conn_open && conn_count < cfg_max_conn |=> conn_accept)
    else $error("open not accepted");
  conn_rej_a: assert property (conn_open && conn_count >= cfg_max_conn |=> conn_reject && !conn_accept)
    else $error("open not rejected");
  gw_on_a: assert property (cfg_mode_gw && (cfg_proto == MGW_PROTO_RTU || cfg_proto == MGW_PROTO_JBUS) |=> gw_active)
    else $error("gateway not active");
  gw_off_a: assert property (!cfg_mode_gw || !(cfg_proto == MGW_PROTO_RTU || cfg_proto == MGW_PROTO_JBUS) |=> !gw_active)
    else $error("gateway active when off");
  tx_hold_a: assert property (ser_tx_valid && !ser_tx_ready |=> ser_tx_valid && $stable(ser_tx_data))
    else $error("serial frame dropped");
  tx_single_a: assert property (tx_done_s |=> !ser_tx_valid) else $error("second frame outstanding");
  loc_hold_a: assert property (loc_valid && !loc_ready |=> loc_valid && $stable(loc_data))
    else $error("local request dropped");
  frame_char_a: assert property (frame_start |-> $past(ser_rx_char)) else $error("start without char");
  exc_pulse_a: assert property (exc_valid |=> !exc_valid) else $error("exception not a pulse");
endmodule

bind mgw_gateway mgw_checker chk (.*);

// >>> sim/mgw_slave_model.sv
`timescale 1ns/1ps
module mgw_slave_model
  import mgw_pkg::*;
(
  input  logic        clk,
  input  logic        rst,
  input  logic        ser_tx_valid,
  input  mgw_req_s    ser_tx_data,
  output logic        ser_tx_ready,
  output logic        ser_rx_char,
  input  logic        mute,
  input  logic [15:0] char_cyc
);
  logic [7:0] u;
  initial
  begin
    ser_tx_ready = 0;
    ser_rx_char = 0;
    forever
    begin
      @(negedge clk);
      if (ser_tx_valid && !rst)
      begin
        u = ser_tx_data.unit;
        repeat (3) @(negedge clk);
        ser_tx_ready = 1;
        @(negedge clk);
        ser_tx_ready = 0;
        // The slave replies to any non-broadcast unit ID unless muted, never to broadcasts
        if (!mute && u != UNIT_BCAST)
          repeat (3)
          begin
            repeat (char_cyc - 1) @(negedge clk);
            ser_rx_char = 1;
            @(negedge clk);
            ser_rx_char = 0;
          end
      end
    end
  end
endmodule

// >>> sim/tb.sv
`timescale 1ns/1ps
module tb;
  import mgw_pkg::*;
  typedef struct packed {logic [7:0] u; logic m; mgw_proto_e p; logic b; logic l; logic s;} mgw_row_s;
  localparam int TK = 10;
  logic              clk, rst, req_valid, req_ready, req_drop, conn_open, conn_close, conn_accept;
  logic              conn_reject, cfg_mode_gw, cfg_bcast_fwd, gw_active, loc_valid, loc_ready;
  logic              ser_tx_valid, ser_tx_ready, ser_rx_char, frame_start, resp_done, exc_valid;
  logic              mute, got, got_s, tx_q;
  mgw_req_s          req_data, loc_data, ser_tx_data, exc_data;
  mgw_proto_e        cfg_proto;
  logic [CONN_W-1:0] conn_count, cfg_max_conn;
  logic [7:0]        cfg_own_unit;
  logic [3:0]        cfg_tmo_sel, cfg_gap_sel, cfg_sil_ext;
  logic [15:0]       cfg_char_cyc;
  int                error_cnt, cmp_count, cyc, t_rdy, t_last, t_done, t_tx, t_exc, n_tx, n_fs, k, f;
  mgw_row_s          rows [8] = '{
    '{8'hFF, 1, MGW_PROTO_RTU, 0, 1, 0}, '{8'h11, 1, MGW_PROTO_RTU, 0, 1, 0},
    '{8'h05, 1, MGW_PROTO_RTU, 0, 0, 1}, '{8'h00, 1, MGW_PROTO_RTU, 0, 1, 0},
    '{8'h00, 1, MGW_PROTO_RTU, 1, 1, 1}, '{8'h05, 0, MGW_PROTO_RTU, 0, 1, 0},
    '{8'h05, 1, MGW_PROTO_OTHER, 0, 1, 0}, '{8'h05, 1, MGW_PROTO_JBUS, 0, 0, 1}};

  mgw_gateway #(.TICK_CYC(TK)) DUT (.*);
  mgw_slave_model PM (.*, .char_cyc(cfg_char_cyc));

  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (ser_tx_valid && ser_tx_ready) t_rdy = cyc;
    if (ser_rx_char) t_last = cyc;
    if (resp_done) t_done = cyc;
    if (frame_start) n_fs++;
    if (exc_valid) t_exc = cyc;
    if (ser_tx_valid && !tx_q)
    begin
      t_tx = cyc;
      n_tx++;
    end
    tx_q = ser_tx_valid;
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("unexpected %s exp %0h got %0h", n, e, g);
      error_cnt++;
    end
  endtask

  task send(input logic [15:0] p, input logic [7:0] u);
    int n;
    n = 0;
    req_data = '{port: p, conn: 4'h0, unit: u, func: 8'h03};
    req_valid = 1;
    while (req_ready !== 1'b1 && n < 200)
    begin
      n++;
      @(negedge clk);
    end
    chk("req_ready", 1, req_ready);
    @(negedge clk);
    req_valid = 0;
  endtask

  task give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #600000;
    $display("unexpected watchdog exp 0 got 1");
    error_cnt++;
    give_verdict();
  end

  initial
  begin
    rst = 1;
    {req_valid, conn_open, conn_close, cfg_bcast_fwd, mute} = 5'h00;
    {cfg_tmo_sel, cfg_gap_sel, cfg_sil_ext} = 12'h000;
    req_data = '0;
    cfg_own_unit = 8'h11;
    cfg_max_conn = 4'h2;
    cfg_char_cyc = 16'h0004;
    cfg_mode_gw = 1;
    cfg_proto = MGW_PROTO_RTU;
    loc_ready = 1;
    repeat (4) @(negedge clk);
    chk("req_ready", 0, req_ready);
    rst = 0;
    repeat (2) @(negedge clk);
    foreach (rows[i])
    begin
      {cfg_mode_gw, cfg_proto, cfg_bcast_fwd} = {rows[i].m, rows[i].p, rows[i].b};
      repeat (2) @(negedge clk);
      got = 0;
      got_s = 0;
      send(MB_TCP_PORT, rows[i].u);
      repeat (150)
      begin
        @(negedge clk);
        got |= loc_valid;
        got_s |= ser_tx_valid;
      end
      chk("local", rows[i].l, got);
      chk("serial", rows[i].s, got_s);
    end
    $display("routing done");
    send(16'h01F7, 8'h05);
    got = 0;
    repeat (3)
    begin
      @(negedge clk);
      got |= req_drop;
    end
    chk("drop", 1, got);
    loc_ready = 0;
    send(MB_TCP_PORT, UNIT_SELF);
    repeat (4) @(negedge clk);
    chk("loc_hold", 1, loc_valid);
    chk("loc_unit", UNIT_SELF, loc_data.unit);
    loc_ready = 1;
    repeat (2) @(negedge clk);
    chk("loc_free", 0, loc_valid);
    for (int i = 0; i < 3; i++)
    begin
      conn_open = 1;
      @(negedge clk);
      conn_open = 0;
      chk("accept", i < 2, conn_accept);
      chk("reject", i >= 2, conn_reject);
      @(negedge clk);
    end
    conn_close = 1;
    @(negedge clk);
    conn_close = 0;
    @(negedge clk);
    chk("count", 1, conn_count);
    $display("drop stall conn done");
    mute = 1;
    send(MB_TCP_PORT, 8'h05);
    for (int n = 0; n < 12000 && t_exc == 0; n++) @(negedge clk);
    k = TMO_MS[0] * TICKS_PER_MS * TK;
    chk("timeout", 1, t_exc - t_rdy >= k && t_exc - t_rdy <= k + 5);
    chk("exc_unit", 8'h05, exc_data.unit);
    mute = 0;
    $display("timeout done");
    {cfg_gap_sel, cfg_sil_ext} = 8'h11;
    k = n_tx;
    f = n_fs;
    send(MB_TCP_PORT, 8'h05);
    @(negedge clk);
    send(MB_TCP_PORT, 8'h06);
    for (int n = 0; n < 3000 && n_tx < k + 2; n++) @(negedge clk);
    k = GAP_STEP_MS * TICKS_PER_MS * TK;
    chk("gap", 1, t_tx - t_done >= k && t_tx - t_done <= k + 5);
    chk("silence", 1, t_done - t_last >= 18 && t_done - t_last <= 20);
    chk("frames", 1, n_fs - f);
    $display("gap silence done");
    repeat (200) @(negedge clk);
    rst = 1;
    repeat (2) @(negedge clk);
    chk("count_rst", 0, conn_count);
    chk("ready_rst", 0, req_ready);
    rst = 0;
    @(negedge clk);
    chk("ready_rel", 1, req_ready);
    $display("reset done");
    give_verdict();
  end
endmodule
